/* File: hdl/pam_consts.vh */
`ifndef PAM_CONSTS_VH
`define PAM_CONSTS_VH

// Anomaly slot indexes inside the latched vectors.
`define PAM_IDX_PARALLEL 0
`define PAM_IDX_SHARED 1
`define PAM_IDX_EXP_SILENT 2
`define PAM_IDX_EXP_MEASURE 3
`define PAM_IDX_EXP_DUP 4
`define PAM_IDX_EXP_SENSOR 5
`define PAM_IDX_TIE_SYNC 6
`define PAM_IDX_MAINS_SYNC 7
`define PAM_IDX_CONFIG 8
`define PAM_IDX_LINE_OPEN 9
`define PAM_IDX_IFACE 10
`define PAM_NUM_ANOM 11

// Numeric anomaly codes.
`define PAM_CODE_PARALLEL 10'h0cf
`define PAM_CODE_SHARED 10'h0d3
`define PAM_CODE_EXP_SILENT 10'h0fc
`define PAM_CODE_EXP_MEASURE 10'h0fd
`define PAM_CODE_EXP_DUP 10'h0fe
`define PAM_CODE_EXP_SENSOR 10'h0ff
`define PAM_CODE_TIE_SYNC 10'h10f
`define PAM_CODE_MAINS_SYNC 10'h110
`define PAM_CODE_CONFIG 10'h111
`define PAM_CODE_LINE_OPEN 10'h112
`define PAM_CODE_IFACE 10'h113
`define PAM_CODE_NONE 10'h000

// Operating mode codes.
`define PAM_MODE_MAN 2'h0
`define PAM_MODE_AUTO 2'h1
`define PAM_MODE_TEST 2'h2
`define PAM_MODE_REMOTE 2'h3

// Mains-breaker opening mask bits.
`define PAM_MASK_MAN 0
`define PAM_MASK_AUTO 1
`define PAM_MASK_TEST 2
`define PAM_MASK_REMOTE 3
`define PAM_MASK_TIE_FAIL 7

// Breaker management codes.
`define PAM_BRK_NOT_MANAGED 3'h0
`define PAM_BRK_STATIC 3'h1
`define PAM_BRK_NON_STATIC 3'h2
`define PAM_BRK_EXTERNAL 3'h3
`define PAM_BRK_EXT_SYNC 3'h4

// Interface-breaker selection codes.
`define PAM_IFACE_OFF 2'h0
`define PAM_IFACE_MAINS 2'h1
`define PAM_IFACE_TIE 2'h2
`define PAM_IFACE_GEN 2'h3

// Timing: one time tick is 100 ms at a 10 ns clock.
`define PAM_CLK_NS 10
`define PAM_TICK_MS 100
`define PAM_TICK_CYCLES (`PAM_TICK_MS * 1000000 / `PAM_CLK_NS)
`define PAM_IFACE_MS 500
`define PAM_IFACE_TICKS (`PAM_IFACE_MS / `PAM_TICK_MS)

`endif

/* File: hdl/pam_anomaly_monitor.v */
`timescale 1ns/100ps
`include "pam_consts.vh"

// How it works
// - Nonzero parallel limit exceeded raises warning 207.
// - Warning 207 opens tie breaker, blocks reclose.
// - Transfer-case 207 self-clears on load drop.
// - Mask chooses modes allowing mains breaker opening.
// - Shared input written twice raises warning 211.
// - Report conflicting input type, number, writer.
// - Expansion checks enabled when any config nonzero.
// - Silent expansion module raises 252, identified.
// - Missing used analogue measure raises 253.
// - Duplicate expansion address raises 254, identified.
// - Disconnected sensor raises 255 with channel.
// - Tie sync timeout raises alarm 271.
// - Mains sync timeout raises warning 272.
// - Sync checks only outside manual mode.
// - Missing feedback or sync input alarms 273.
// - Factory parameters never set alarms 273.
// - Non-paralleling plant with unmanaged mains alarms.
// - Peer lacking coordination mode warns 273.
// - Line-open input, even briefly, alarms 274.
// - Interface breaker not open in 0.5s alarms.
module pam_anomaly_monitor #(
    parameter TICK_CYCLES = `PAM_TICK_CYCLES
) (
    input wire core_clk,
    input wire arst_n,
    input wire [1:0] opMode,
    input wire operatorAck,
    input wire gridParallel,
    input wire [15:0] maxParallelTicks,
    input wire transferToGensets,
    input wire loadPowerFell,
    input wire gensetsAdded,
    input wire tieOpenFailed,
    input wire [7:0] mainsOpenMask,
    input wire sharedConflict,
    input wire [3:0] sharedType,
    input wire [7:0] sharedNumber,
    input wire [7:0] sharedWriterAddr,
    input wire [7:0] expCfg0,
    input wire [7:0] expCfg1,
    input wire [7:0] expCfg2,
    input wire [7:0] expCfg3,
    input wire [3:0] moduleSilent,
    input wire measureMissing,
    input wire [7:0] measureFunction,
    input wire [1:0] measureModule,
    input wire [3:0] measureChannel,
    input wire [3:0] moduleDupAddr,
    input wire sensorDisconnected,
    input wire [1:0] sensorModule,
    input wire [3:0] sensorChannel,
    input wire tieSyncActive,
    input wire tieClosed,
    input wire [15:0] tieSyncTicks,
    input wire mainsSyncActive,
    input wire mainsClosed,
    input wire [15:0] mainsSyncTicks,
    input wire [2:0] mainsBreakerMode,
    input wire [2:0] tieBreakerMode,
    input wire mainsFeedbackAssigned,
    input wire tieFeedbackAssigned,
    input wire mainsSyncReqAssigned,
    input wire tieSyncReqAssigned,
    input wire factoryParamsSet,
    input wire plantIsMainsParallel,
    input wire coordModeZero,
    input wire peerLacksCoordMode,
    input wire lineOpenInput,
    input wire lossOfMains,
    input wire [1:0] interfaceSelect,
    input wire generatorBreakerClosed,
    output reg tieOpenCmd,
    output reg tieCloseInhibit,
    output reg mainsOpenCmd,
    output reg lineOpenMsg,
    output reg [10:0] anomalyActive,
    output reg [10:0] anomalyAlarm,
    output reg [9:0] anomalyCode,
    output reg anomalyIsAlarm,
    output reg [3:0] conflictType,
    output reg [7:0] conflictNumber,
    output reg [7:0] conflictWriter,
    output reg [1:0] expFaultModule,
    output reg [3:0] expFaultChannel
);
    localparam ST_NORMAL = 2'b01;
    localparam ST_HELD = 2'b10;
    reg [1:0] tieState;
    reg [1:0] next_tieState;
    reg transferCase;
    reg [31:0] tickCnt;
    reg tick;
    reg [15:0] parallelCnt;
    reg [15:0] tieSyncCnt;
    reg [15:0] mainsSyncCnt;
    reg [15:0] ifaceCnt;
    reg [10:0] raise;
    reg [10:0] raiseAlarm;
    reg [10:0] selfClear;
    reg cfgAlarm;
    reg ifaceClosed;
    reg [9:0] next_code;
    reg next_isAlarm;
    integer i;
    wire isMan = (opMode == `PAM_MODE_MAN);
    wire expEnable = |{expCfg0, expCfg1, expCfg2, expCfg3};
    // Saturating tick counter shared by all timers.
    function [15:0] satInc;
        input [15:0] cnt;
        input run;
        begin
            if (!run) begin
                satInc = 16'h0000;
            end else if (tick && cnt != 16'hffff) begin
                satInc = cnt + 16'h0001;
            end else begin
                satInc = cnt;
            end
        end
    endfunction
    // Lowest numbered module in a fault vector.
    function [1:0] firstModule;
        input [3:0] v;
        begin
            if (v[0]) begin
                firstModule = 2'h0;
            end else if (v[1]) begin
                firstModule = 2'h1;
            end else if (v[2]) begin
                firstModule = 2'h2;
            end else begin
                firstModule = 2'h3;
            end
        end
    endfunction
    function [9:0] codeOf;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: codeOf = `PAM_CODE_PARALLEL;
                4'h1: codeOf = `PAM_CODE_SHARED;
                4'h2: codeOf = `PAM_CODE_EXP_SILENT;
                4'h3: codeOf = `PAM_CODE_EXP_MEASURE;
                4'h4: codeOf = `PAM_CODE_EXP_DUP;
                4'h5: codeOf = `PAM_CODE_EXP_SENSOR;
                4'h6: codeOf = `PAM_CODE_TIE_SYNC;
                4'h7: codeOf = `PAM_CODE_MAINS_SYNC;
                4'h8: codeOf = `PAM_CODE_CONFIG;
                4'h9: codeOf = `PAM_CODE_LINE_OPEN;
                4'ha: codeOf = `PAM_CODE_IFACE;
                default: codeOf = `PAM_CODE_NONE;
            endcase
        end
    endfunction
    // Timers run on a 100 ms tick, so every limit resolves to within one tick.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tickCnt <= 32'h00000000;
            tick <= 1'b0;
        end else if (tickCnt >= TICK_CYCLES - 1) begin
            tickCnt <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            tickCnt <= tickCnt + 32'h00000001;
            tick <= 1'b0;
        end
    end

    always @* begin
        case (interfaceSelect)
            `PAM_IFACE_MAINS: ifaceClosed = mainsClosed;
            `PAM_IFACE_TIE: ifaceClosed = tieClosed;
            `PAM_IFACE_GEN: ifaceClosed = generatorBreakerClosed;
            default: ifaceClosed = 1'b0;
        endcase
        cfgAlarm = 1'b0;
        if ((mainsBreakerMode == `PAM_BRK_EXTERNAL || mainsBreakerMode == `PAM_BRK_NON_STATIC
                || mainsBreakerMode == `PAM_BRK_EXT_SYNC) && !mainsFeedbackAssigned) begin
            cfgAlarm = 1'b1;
        end
        if ((tieBreakerMode == `PAM_BRK_EXTERNAL || tieBreakerMode == `PAM_BRK_NON_STATIC
                || tieBreakerMode == `PAM_BRK_EXT_SYNC) && !tieFeedbackAssigned) begin
            cfgAlarm = 1'b1;
        end
        if ((mainsBreakerMode == `PAM_BRK_EXT_SYNC && !mainsSyncReqAssigned)
                || (tieBreakerMode == `PAM_BRK_EXT_SYNC && !tieSyncReqAssigned)) begin
            cfgAlarm = 1'b1;
        end
        if (!factoryParamsSet) begin
            cfgAlarm = 1'b1;
        end
        if (!plantIsMainsParallel && mainsBreakerMode == `PAM_BRK_NOT_MANAGED) begin
            cfgAlarm = 1'b1;
        end

        raise = 11'h000;
        raiseAlarm = 11'h000;
        selfClear = 11'h000;
        raise[`PAM_IDX_PARALLEL] = gridParallel && maxParallelTicks != 16'h0000
            && parallelCnt > maxParallelTicks;
        raise[`PAM_IDX_SHARED] = sharedConflict;
        raise[`PAM_IDX_EXP_SILENT] = expEnable && |moduleSilent;
        raise[`PAM_IDX_EXP_MEASURE] = expEnable && measureMissing && measureFunction != 8'h00;
        raise[`PAM_IDX_EXP_DUP] = expEnable && |moduleDupAddr;
        raise[`PAM_IDX_EXP_SENSOR] = expEnable && sensorDisconnected;
        // tie sync timeout, not in manual
        raise[`PAM_IDX_TIE_SYNC] = !isMan && tieSyncActive && !tieClosed
            && tieSyncTicks != 16'h0000 && tieSyncCnt >= tieSyncTicks;
        raiseAlarm[`PAM_IDX_TIE_SYNC] = !isMan;
        // mains sync timeout, not in manual
        raise[`PAM_IDX_MAINS_SYNC] = !isMan && mainsSyncActive && !mainsClosed
            && mainsSyncTicks != 16'h0000 && mainsSyncCnt >= mainsSyncTicks;
        raise[`PAM_IDX_CONFIG] = cfgAlarm || (coordModeZero && peerLacksCoordMode);
        raiseAlarm[`PAM_IDX_CONFIG] = cfgAlarm;
        raise[`PAM_IDX_LINE_OPEN] = lineOpenInput;
        raiseAlarm[`PAM_IDX_LINE_OPEN] = 1'b1;
        raise[`PAM_IDX_IFACE] = interfaceSelect != `PAM_IFACE_OFF
            && ifaceCnt >= `PAM_IFACE_TICKS;
        raiseAlarm[`PAM_IDX_IFACE] = 1'b1;
        selfClear[`PAM_IDX_PARALLEL] = transferCase && (loadPowerFell || gensetsAdded);
    end

    always @* begin
        next_code = `PAM_CODE_NONE;
        next_isAlarm = 1'b0;
        for (i = `PAM_NUM_ANOM - 1; i >= 0; i = i - 1) begin
            if (anomalyActive[i]) begin
                next_code = codeOf(i[3:0]);
                next_isAlarm = anomalyAlarm[i];
            end
        end
        case (tieState)
            ST_NORMAL: next_tieState = raise[`PAM_IDX_PARALLEL] ? ST_HELD : ST_NORMAL;
            ST_HELD: begin
                if (!raise[`PAM_IDX_PARALLEL]
                        && (operatorAck || selfClear[`PAM_IDX_PARALLEL])) begin
                    next_tieState = ST_NORMAL;
                end else begin
                    next_tieState = ST_HELD;
                end
            end
            default: next_tieState = ST_NORMAL;
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            parallelCnt <= 16'h0000;
            tieSyncCnt <= 16'h0000;
            mainsSyncCnt <= 16'h0000;
            ifaceCnt <= 16'h0000;
            tieState <= ST_NORMAL;
            transferCase <= 1'b0;
            anomalyActive <= 11'h000;
            anomalyAlarm <= 11'h000;
            anomalyCode <= `PAM_CODE_NONE;
            anomalyIsAlarm <= 1'b0;
            tieOpenCmd <= 1'b0;
            tieCloseInhibit <= 1'b0;
            mainsOpenCmd <= 1'b0;
            lineOpenMsg <= 1'b0;
            conflictType <= 4'h0;
            conflictNumber <= 8'h00;
            conflictWriter <= 8'h00;
            expFaultModule <= 2'h0;
            expFaultChannel <= 4'h0;
        end else begin
            parallelCnt <= satInc(parallelCnt, gridParallel);
            tieSyncCnt <= satInc(tieSyncCnt, tieSyncActive && !tieClosed);
            mainsSyncCnt <= satInc(mainsSyncCnt, mainsSyncActive && !mainsClosed);
            // count only in grid parallel after loss of mains
            ifaceCnt <= satInc(ifaceCnt, gridParallel && lossOfMains && ifaceClosed);
            tieState <= next_tieState;
            anomalyActive <= raise | (anomalyActive & ~selfClear & ~{11{operatorAck}});
            anomalyAlarm <= (raise & raiseAlarm) | (anomalyAlarm & ~raise);
            anomalyCode <= next_code;
            anomalyIsAlarm <= next_isAlarm;
            // open tie breaker and hold it open
            tieOpenCmd <= raise[`PAM_IDX_PARALLEL];
            tieCloseInhibit <= next_tieState == ST_HELD;
            if (raise[`PAM_IDX_PARALLEL] && tieState == ST_NORMAL) begin
                transferCase <= transferToGensets;
            end
            mainsOpenCmd <= raise[`PAM_IDX_PARALLEL] && !anomalyActive[`PAM_IDX_PARALLEL]
                && (mainsOpenMask[{1'b0, opMode}]
                || (mainsOpenMask[`PAM_MASK_TIE_FAIL] && tieOpenFailed));
            // message to gensets, they open their breakers
            lineOpenMsg <= lineOpenInput;
            if (sharedConflict) begin
                conflictType <= sharedType;
                conflictNumber <= sharedNumber;
                conflictWriter <= sharedWriterAddr;
            end
            if (raise[`PAM_IDX_EXP_SENSOR]) begin
                expFaultModule <= sensorModule;
                expFaultChannel <= sensorChannel;
            end else if (raise[`PAM_IDX_EXP_MEASURE]) begin
                expFaultModule <= measureModule;
                expFaultChannel <= measureChannel;
            end else if (raise[`PAM_IDX_EXP_DUP]) begin
                expFaultModule <= firstModule(moduleDupAddr);
                expFaultChannel <= 4'h0;
            end else if (raise[`PAM_IDX_EXP_SILENT]) begin
                expFaultModule <= firstModule(moduleSilent);
                expFaultChannel <= 4'h0;
            end
        end
    end

endmodule // pam_anomaly_monitor

/* File: test/pam_monitor_props.sv */
`timescale 1ns/100ps
`include "pam_consts.vh"
module pam_monitor_props (
    input wire core_clk,
    input wire arst_n,
    input wire [1:0] opMode,
    input wire sharedConflict,
    input wire [7:0] sharedWriterAddr,
    input wire [7:0] expCfg0,
    input wire [7:0] expCfg1,
    input wire [7:0] expCfg2,
    input wire [7:0] expCfg3,
    input wire [3:0] moduleSilent,
    input wire measureMissing,
    input wire [7:0] measureFunction,
    input wire sensorDisconnected,
    input wire [3:0] sensorChannel,
    input wire lineOpenInput,
    input wire lineOpenMsg,
    input wire [10:0] anomalyActive,
    input wire [10:0] anomalyAlarm,
    input wire [9:0] anomalyCode,
    input wire anomalyIsAlarm,
    input wire [7:0] conflictWriter,
    input wire [3:0] expFaultChannel
);
    wire cfgOn = |{expCfg0, expCfg1, expCfg2, expCfg3};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_line;
        lineOpenInput |=> lineOpenMsg && anomalyActive[9] && anomalyAlarm[9];
    endproperty
    a_line: assert property (p_line) else $error("line open not latched");
    property p_shared;
        sharedConflict |=> anomalyActive[1] && conflictWriter == $past(sharedWriterAddr);
    endproperty
    a_shared: assert property (p_shared) else $error("shared conflict lost");
    property p_exp_off;
        $rose(|anomalyActive[5:2]) |-> $past(cfgOn);
    endproperty
    a_exp_off: assert property (p_exp_off) else $error("expansion fault while off");
    property p_silent;
        cfgOn && moduleSilent != 4'h0 |=> anomalyActive[2];
    endproperty
    a_silent: assert property (p_silent) else $error("silent module missed");
    property p_measure;
        $rose(anomalyActive[3]) |-> $past(measureMissing && measureFunction != 8'h00);
    endproperty
    a_measure: assert property (p_measure) else $error("unused measure flagged");
    property p_sensor;
        cfgOn && sensorDisconnected |=> anomalyActive[5] && expFaultChannel == $past(sensorChannel);
    endproperty
    a_sensor: assert property (p_sensor) else $error("sensor fault wrong");
    property p_sync;
        $rose(anomalyActive[6]) || $rose(anomalyActive[7]) |-> $past(opMode) != `PAM_MODE_MAN;
    endproperty
    a_sync: assert property (p_sync) else $error("sync fault in manual");
    property p_code;
        anomalyActive == 11'h200 |=> anomalyCode == `PAM_CODE_LINE_OPEN && anomalyIsAlarm;
    endproperty
    a_code: assert property (p_code) else $error("code not reported");
endmodule // pam_monitor_props

bind pam_anomaly_monitor pam_monitor_props i_props (.*);

/* File: test/pam_far_side.sv */
`timescale 1ns/100ps
module pam_far_side (
    input wire core_clk,
    input wire [3:0] silentReq,
    input wire closeGen,
    input wire lineOpenMsg,
    input wire lossOfMains,
    input wire [1:0] interfaceSelect,
    output reg [3:0] moduleSilent,
    output reg generatorBreakerClosed
);
    reg [3:0] silentDly;
    initial begin
        {silentDly, moduleSilent, generatorBreakerClosed} = 9'h0;
    end
    // Two stages, so a module falls silent or wakes late, as on a real bus.
    always @(posedge core_clk) begin
        silentDly <= silentReq;
        moduleSilent <= silentDly;
    end
    always @(posedge core_clk) begin
        generatorBreakerClosed <= !lineOpenMsg && !(lossOfMains && interfaceSelect == 2'h0)
            && (generatorBreakerClosed || closeGen);
    end
endmodule // pam_far_side

/* File: test/test_paralleling_anomaly_monitor.sv */
`timescale 1ns/100ps
`include "pam_consts.vh"
module test_paralleling_anomaly_monitor;
    logic core_clk = 0;
    logic arst_n = 0;
    logic operatorAck, gridParallel, transferToGensets, loadPowerFell, gensetsAdded, tieOpenFailed;
    logic sharedConflict, measureMissing, sensorDisconnected, tieSyncActive, tieClosed, closeGen;
    logic mainsSyncActive, mainsClosed, mainsFeedbackAssigned, tieFeedbackAssigned;
    logic mainsSyncReqAssigned, tieSyncReqAssigned, factoryParamsSet, plantIsMainsParallel;
    logic coordModeZero, peerLacksCoordMode, lineOpenInput, lossOfMains, generatorBreakerClosed;
    logic tieOpenCmd, tieCloseInhibit, mainsOpenCmd, lineOpenMsg, anomalyIsAlarm;
    logic [1:0] opMode, measureModule, sensorModule, interfaceSelect, expFaultModule;
    logic [2:0] mainsBreakerMode, tieBreakerMode;
    logic [3:0] sharedType, moduleSilent, measureChannel, moduleDupAddr, sensorChannel;
    logic [3:0] conflictType, expFaultChannel, silentReq;
    logic [7:0] mainsOpenMask, sharedNumber, sharedWriterAddr, expCfg0, expCfg1, expCfg2, expCfg3;
    logic [7:0] measureFunction, conflictNumber, conflictWriter, rnd;
    logic [9:0] anomalyCode;
    logic [10:0] anomalyActive, anomalyAlarm;
    logic [15:0] maxParallelTicks, tieSyncTicks, mainsSyncTicks;
    int errors = 0;
    int tests_run = 0;
    int codes [11] = '{207, 211, 252, 253, 254, 255, 271, 272, 273, 274, 275};
    pam_anomaly_monitor #(.TICK_CYCLES(4)) i_pam_anomaly_monitor (.*);
    pam_far_side i_far (.*);
    always #5 core_clk = ~core_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // The lowest slot index wins the reported code.
    function automatic int code_of(input logic [10:0] a);
        int c = 0;
        for (int i = 10; i >= 0; i--) if (a[i]) c = codes[i];
        return c;
    endfunction
    task automatic complete_run();
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic wait_bit(input int idx, input int n, input logic e);
        logic seen = 0;
        for (int k = 0; k < n && !seen; k++) begin
            @(negedge core_clk);
            seen = (anomalyActive[idx] === 1'b1);
        end
        chk("raised", seen, e);
        if (e && !seen)
            complete_run();
    endtask
    task automatic settle(input logic [10:0] a);
        repeat (3) @(negedge core_clk);
        chk("anomalyActive", anomalyActive, a);
        chk("anomalyCode", anomalyCode, code_of(a));
    endtask
    // The wait lets slow partner answers land before the acknowledge is taken.
    task automatic ack();
        repeat (4) @(negedge core_clk);
        operatorAck = 1;
        @(negedge core_clk);
        operatorAck = 0;
    endtask
    initial begin
        {operatorAck, gridParallel, transferToGensets, loadPowerFell, gensetsAdded} = '0;
        {tieOpenFailed, sharedConflict, measureMissing, sensorDisconnected, tieSyncActive} = '0;
        {tieClosed, closeGen, mainsSyncActive, mainsClosed, mainsFeedbackAssigned} = '0;
        {tieFeedbackAssigned, coordModeZero, mainsSyncReqAssigned, tieSyncReqAssigned} = '0;
        {peerLacksCoordMode, lineOpenInput, lossOfMains, opMode, measureModule} = '0;
        {sensorModule, interfaceSelect, sharedType, measureChannel, moduleDupAddr} = '0;
        {sensorChannel, silentReq, mainsOpenMask, sharedNumber, sharedWriterAddr} = '0;
        {expCfg0, expCfg1, expCfg2, expCfg3, measureFunction, maxParallelTicks} = '0;
        {tieSyncTicks, mainsSyncTicks} = '0;
        {factoryParamsSet, plantIsMainsParallel, mainsBreakerMode, tieBreakerMode} = {2'h3, 6'h09};
        rnd = 8'h5c;
        repeat (2) @(negedge core_clk);
        arst_n = 1;
        closeGen = 1;
        @(negedge core_clk);
        {closeGen, lineOpenInput} = 2'h1;
        @(negedge core_clk);
        lineOpenInput = 0;
        settle(11'h200);
        chk("genBrk", generatorBreakerClosed, 0);
        ack();
        rnd = lfsr(rnd);
        {sharedType, sharedNumber, sharedWriterAddr, sharedConflict} = {rnd[3:0], rnd, ~rnd, 1'b1};
        @(negedge core_clk);
        sharedConflict = 0;
        settle(11'h002);
        chk("cType", conflictType, rnd[3:0]);
        chk("cNum", conflictNumber, rnd);
        chk("cWr", conflictWriter, rnd ^ 8'hff);
        ack();
        rnd = lfsr(rnd);
        silentReq = 4'h6;
        wait_bit(2, 12, 0);
        expCfg2 = rnd | 8'h01;
        settle(11'h004);
        chk("eMod", expFaultModule, 1);
        {silentReq, moduleDupAddr} = 8'h08;
        ack();
        settle(11'h010);
        chk("eMod", expFaultModule, 3);
        {moduleDupAddr, measureMissing} = 5'h01;
        ack();
        settle(11'h000);
        {measureFunction, measureModule, measureChannel} = {rnd | 8'h01, 2'h2, rnd[7:4]};
        settle(11'h008);
        chk("eMod", expFaultModule, 2);
        chk("eCh", expFaultChannel, rnd[7:4]);
        {measureMissing, sensorDisconnected, sensorModule, sensorChannel} = {4'h5, rnd[3:0]};
        ack();
        settle(11'h020);
        chk("eCh", expFaultChannel, rnd[3:0]);
        chk("eMod", expFaultModule, 1);
        {sensorDisconnected, expCfg2} = 9'h0;
        ack();
        for (int i = 0; i < 6; i++) begin
            case (i)
                0: factoryParamsSet = 0;
                1: {plantIsMainsParallel, mainsBreakerMode} = {1'b0, `PAM_BRK_NOT_MANAGED};
                2: mainsBreakerMode = `PAM_BRK_EXTERNAL;
                3: tieBreakerMode = `PAM_BRK_NON_STATIC;
                4: {tieBreakerMode, tieFeedbackAssigned} = {`PAM_BRK_EXT_SYNC, 1'b1};
                default: {coordModeZero, peerLacksCoordMode} = 2'h3;
            endcase
            settle(11'h100);
            chk("class", anomalyIsAlarm, i < 5);
            {factoryParamsSet, plantIsMainsParallel, mainsBreakerMode, tieBreakerMode} = 8'hc9;
            {tieFeedbackAssigned, coordModeZero, peerLacksCoordMode} = 3'h0;
            ack();
        end
        maxParallelTicks = 3;
        for (int m = 0; m < 5; m++) begin
            mainsOpenMask = (m == 4) ? 8'h80 : 8'h05;
            {tieOpenFailed, opMode, gridParallel} = {m == 4, 2'(m), 1'b1};
            wait_bit(0, 8, 0);
            wait_bit(0, 16, 1);
            chk("mOpen", mainsOpenCmd, m == 4 || mainsOpenMask[m]);
            chk("tOpen", tieOpenCmd & tieCloseInhibit, 1);
            gridParallel = 0;
            settle(11'h001);
            chk("held", tieCloseInhibit, 1);
            ack();
            settle(11'h000);
            chk("inhibit", tieCloseInhibit, 0);
        end
        {maxParallelTicks, gridParallel, tieOpenFailed} = 18'h2;
        wait_bit(0, 30, 0);
        for (int s = 1; s < 4; s++) begin
            {lossOfMains, interfaceSelect, mainsClosed, tieClosed, closeGen} =
                {1'b1, 2'(s), s == 1, s == 2, s == 3};
            wait_bit(10, 14, 0);
            wait_bit(10, 14, 1);
            chk("alarm", anomalyAlarm[10], 1);
            {lossOfMains, interfaceSelect, mainsClosed, tieClosed, closeGen} = 6'h0;
            ack();
        end
        lossOfMains = 1;
        wait_bit(10, 30, 0);
        chk("genBrk", generatorBreakerClosed, 0);
        {gridParallel, lossOfMains} = 2'h0;
        for (int g = 0; g < 2; g++) begin
            {maxParallelTicks, transferToGensets, gridParallel, loadPowerFell, gensetsAdded} =
                {16'h0002, 4'hc};
            wait_bit(0, 24, 1);
            {gridParallel, loadPowerFell, gensetsAdded} = {1'b0, g == 0, g == 1};
            settle(11'h000);
            chk("inhibit", tieCloseInhibit, 0);
        end
        {transferToGensets, loadPowerFell, gensetsAdded} = 3'h0;
        {tieSyncTicks, mainsSyncTicks} = 32'h00020002;
        tieSyncActive = 1;
        wait_bit(6, 24, 0);
        tieSyncActive = 0;
        @(negedge core_clk);
        {opMode, tieSyncActive} = {`PAM_MODE_AUTO, 1'b1};
        wait_bit(6, 3, 0);
        wait_bit(6, 16, 1);
        chk("alarm", anomalyAlarm[6], 1);
        {tieSyncActive, opMode, mainsSyncActive} = {1'b0, `PAM_MODE_TEST, 1'b1};
        wait_bit(7, 16, 1);
        chk("alarm", anomalyAlarm[7], 0);
        mainsSyncActive = 0;
        ack();
        settle(11'h000);
        complete_run();
    end
endmodule // test_paralleling_anomaly_monitor
